// >>> rcf_top.sv
// Reconfiguration event control, network probe, fault reporting, AXI4-Lite registers
`timescale 1ns/1ps
`include "rcf_params.svh"
module rcf_top
  import rcf_pkg::*;
#(
  parameter int unsigned MS_CYC = `RCF_MS_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // Technician switch and power
  input  wire logic        switch_i,
  input  wire logic        premium_i,
  // Diagnostic link request and report
  input  wire logic        diag_start_i,
  input  wire logic        diag_dtc_req_i,
  output logic             diag_dtc_vld_o,
  output logic [7:0]       diag_dtc_o,
  // Vehicle network probe
  output logic             net_probe_o,
  input  wire logic        net_done_i,
  input  wire rcf_net_t    net_i,
  // Wheel hardware sense
  input  wire logic [3:0]  sensor_cnt_i,
  input  wire logic [3:0]  valve_cnt_i,
  input  wire rcf_xv_t     xv_i,
  // Self-test
  input  wire logic        fault_i,
  input  wire logic [7:0]  fault_code_i,
  input  wire logic [3:0]  fault_lamp_i,
  input  wire logic [1:0]  fault_shut_i,
  // Lamps and function control
  output logic [3:0]       lamp_o,
  output logic [1:0]       shut_o,
  output logic             relay_en_o,
  output logic             retarder_com_o,
  // Non-volatile store
  output logic             nv_wr_o,
  output rcf_cfg_t         nv_cfg_o,
  input  wire logic        nv_ack_i,
  // AXI4-Lite slave
  input  wire logic [11:0] s_awaddr_i,
  input  wire logic        s_awvalid_i,
  output logic             s_awready_o,
  input  wire logic [31:0] s_wdata_i,
  input  wire logic [3:0]  s_wstrb_i,
  input  wire logic        s_wvalid_i,
  output logic             s_wready_o,
  output logic [1:0]       s_bresp_o,
  output logic             s_bvalid_o,
  input  wire logic        s_bready_i,
  input  wire logic [11:0] s_araddr_i,
  input  wire logic        s_arvalid_i,
  output logic             s_arready_o,
  output logic [31:0]      s_rdata_o,
  output logic [1:0]       s_rresp_o,
  output logic             s_rvalid_o,
  input  wire logic        s_rready_i,
  output logic             irq_o
);
  localparam int unsigned PMIN  = `RCF_PRESS_MIN_MS;
  localparam int unsigned PMAX  = `RCF_PRESS_MAX_MS;
  localparam int unsigned GMAX  = `RCF_GAP_MAX_MS;
  localparam int unsigned PAUSE = `RCF_PAUSE_MS;

  function automatic logic is_ofs(input logic [11:0] a, input logic [11:0] o);
    is_ofs = (a[11:2] == o[11:2]);
  endfunction : is_ofs

  rcf_state_t              state_r;
  rcf_cfg_t                cfg_r;
  rcf_cfg_t                probe_cfg;
  logic [16:0]             ms_div_r;
  logic                    ms_tick;
  logic [12:0]             hi_ms_r;
  logic [12:0]             lo_ms_r;
  logic                    sw_d_r;
  logic                    armed_r;
  logic                    boot_r;
  logic                    held_r;
  logic [3:0]              press_r;
  logic                    sw_start;
  logic                    sw_fault;
  logic                    start;
  logic [`RCF_IRQ_W-1:0]   irq_sts_r;
  logic [`RCF_IRQ_W-1:0]   irq_msk_r;
  logic [`RCF_IRQ_W-1:0]   irq_ev;
  logic [`RCF_IRQ_W-1:0]   irq_w1c;
  logic [7:0]              dtc_r;
  logic                    dtc_vld_r;
  logic                    sw_cmd;
  logic                    done_ev;
  logic [11:0]             awa_r;
  logic                    aw_r;
  logic                    w_r;
  logic [31:0]             wd_r;
  logic                    wr_go;
  logic                    rd_go;

  // Millisecond base for switch timing
  assign ms_tick = (ms_div_r == 17'(MS_CYC - 1));
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ms_div_r <= 17'h00000;
    end else if (ms_tick) begin
      ms_div_r <= 17'h00000;
    end else begin
      ms_div_r <= ms_div_r + 17'h00001;
    end
  end

  // Switch press qualification; boot_r catches the switch held at release of reset
  assign sw_fault = switch_i && ms_tick && (hi_ms_r == 13'(PMAX - 1));
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_d_r  <= 1'b0;
      hi_ms_r <= 13'h0000;
      lo_ms_r <= 13'h0000;
      press_r <= 4'h0;
      armed_r <= 1'b0;
      boot_r  <= 1'b1;
      held_r  <= 1'b0;
    end else begin
      sw_d_r <= switch_i;
      if (boot_r) begin
        boot_r  <= 1'b0;
        armed_r <= switch_i;
        held_r  <= switch_i;
      end
      if (switch_i && ms_tick && hi_ms_r != 13'h1fff) begin
        hi_ms_r <= hi_ms_r + 13'h0001;
      end
      if (!switch_i && ms_tick && lo_ms_r != 13'h1fff) begin
        lo_ms_r <= lo_ms_r + 13'h0001;
      end
      if (switch_i && !sw_d_r) begin
        lo_ms_r <= 13'h0000;
        // Long gap breaks the sequence
        if (lo_ms_r > 13'(GMAX)) begin
          press_r <= 4'h0;
        end
      end
      if (!switch_i && sw_d_r) begin
        hi_ms_r <= 13'h0000;
        held_r  <= 1'b0;
        // First release after power-up only ends the held phase
        if (armed_r && !held_r && hi_ms_r >= 13'(PMIN) && hi_ms_r < 13'(PMAX)) begin
          press_r <= (press_r == 4'hf) ? press_r : press_r + 4'h1;
        end
      end
      if (sw_fault) begin
        press_r <= 4'h0;
      end
      if (sw_start || (!switch_i && lo_ms_r == 13'(PAUSE) && ms_tick)) begin
        press_r <= 4'h0;
        armed_r <= 1'b0;
      end
    end
  end
  assign sw_start = armed_r && !switch_i && ms_tick && lo_ms_r == 13'(PAUSE - 1)
                  && press_r == 4'(`RCF_PRESS_CNT);
  assign start    = (sw_start || diag_start_i || sw_cmd) && state_r == ST_IDLE;

  // Probe result to configuration
  always_comb begin
    probe_cfg                 = cfg_r;
    probe_cfg.retarder        = net_i.retarder;
    probe_cfg.relay_ctl       = net_i.relay;
    probe_cfg.rsvd            = 4'h0;
    if (premium_i) begin
      probe_cfg.traction_assist              = net_i.traction_assist && net_i.relay_ok;
      probe_cfg.sensor_cnt                   = sensor_cnt_i;
      probe_cfg.pressure_modulator_valve_cnt = valve_cnt_i;
      probe_cfg.six_sensor_five_valve        = xv_i.hold_r && xv_i.rel_l && xv_i.com_r;
    end
  end

  // Reconfiguration sequence
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r     <= ST_IDLE;
      cfg_r       <= `RCF_CFG_RESET;
      net_probe_o <= 1'b0;
      nv_wr_o     <= 1'b0;
      nv_cfg_o    <= `RCF_CFG_RESET;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r     <= ST_PROBE;
            net_probe_o <= 1'b1;
          end
        end
        ST_PROBE: begin
          if (net_done_i) begin
            net_probe_o <= 1'b0;
            cfg_r       <= probe_cfg;
            nv_cfg_o    <= probe_cfg;
            nv_wr_o     <= 1'b1;
            state_r     <= ST_SAVE;
          end
        end
        ST_SAVE: begin
          if (nv_ack_i) begin
            nv_wr_o <= 1'b0;
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
  assign done_ev = (state_r == ST_DONE);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      relay_en_o     <= 1'b0;
      retarder_com_o <= 1'b0;
    end else begin
      relay_en_o     <= cfg_r.relay_ctl;
      retarder_com_o <= cfg_r.retarder;
    end
  end

  // Fault handling: lamps, shutdown, trouble code
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lamp_o         <= 4'h0;
      shut_o         <= 2'b00;
      dtc_r          <= 8'h00;
      dtc_vld_r      <= 1'b0;
      diag_dtc_vld_o <= 1'b0;
      diag_dtc_o     <= 8'h00;
    end else begin
      diag_dtc_vld_o <= 1'b0;
      if (fault_i) begin
        lamp_o    <= lamp_o | fault_lamp_i;
        shut_o    <= shut_o | fault_shut_i;
        dtc_r     <= fault_code_i;
        dtc_vld_r <= 1'b1;
      end
      if (diag_dtc_req_i && dtc_vld_r) begin
        diag_dtc_vld_o <= 1'b1;
        diag_dtc_o     <= dtc_r;
      end
    end
  end

  // Interrupt status, set wins over clear
  assign irq_ev = {sw_fault, fault_i, done_ev, start};
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_sts_r <= '0;
      irq_o     <= 1'b0;
    end else begin
      irq_sts_r <= (irq_sts_r & ~irq_w1c) | irq_ev;
      irq_o     <= |(irq_sts_r & irq_msk_r);
    end
  end

  // AXI4-Lite write: address and data in either order
  assign wr_go = aw_r && w_r && !s_bvalid_o;
  assign irq_w1c = (wr_go && is_ofs(awa_r, `RCF_IRQ_OFS)) ? wd_r[`RCF_IRQ_W-1:0] : '0;
  assign sw_cmd  = wr_go && is_ofs(awa_r, `RCF_CMD_OFS) && wd_r[0];
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_r       <= 1'b0;
      w_r        <= 1'b0;
      awa_r      <= 12'h000;
      wd_r       <= 32'h00000000;
      s_bvalid_o <= 1'b0;
      s_bresp_o  <= `RCF_RESP_OKAY;
      irq_msk_r  <= '0;
      s_awready_o <= 1'b1;
      s_wready_o  <= 1'b1;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_r  <= 1'b1;
        awa_r <= s_awaddr_i;
        s_awready_o <= 1'b0;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_r  <= 1'b1;
        wd_r <= s_wdata_i;
        s_wready_o <= 1'b0;
      end
      if (wr_go) begin
        aw_r       <= 1'b0;
        w_r        <= 1'b0;
        s_bvalid_o <= 1'b1;
        s_bresp_o  <= `RCF_RESP_OKAY;
        if (is_ofs(awa_r, `RCF_MASK_OFS)) begin
          irq_msk_r <= wd_r[`RCF_IRQ_W-1:0];
        end else if (!is_ofs(awa_r, `RCF_IRQ_OFS) && !is_ofs(awa_r, `RCF_CMD_OFS)) begin
          s_bresp_o <= `RCF_RESP_SLVERR;
        end
      end else if (s_bvalid_o && s_bready_i) begin
        s_bvalid_o <= 1'b0;
        // Ready returns only once the response is taken
        s_awready_o <= 1'b1;
        s_wready_o  <= 1'b1;
      end
    end
  end
  // Byte strobes ignored: all writable fields sit in the low byte
  logic unused_strb;
  assign unused_strb = ^s_wstrb_i;

  // AXI4-Lite read
  assign rd_go       = s_arvalid_i && s_arready_o;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_rvalid_o  <= 1'b0;
      s_arready_o <= 1'b1;
      s_rdata_o   <= 32'h00000000;
      s_rresp_o   <= `RCF_RESP_OKAY;
    end else if (rd_go) begin
      s_rvalid_o  <= 1'b1;
      s_arready_o <= 1'b0;
      s_rresp_o  <= `RCF_RESP_OKAY;
      s_rdata_o  <= 32'h00000000;
      if (is_ofs(s_araddr_i, `RCF_CFG_OFS)) begin
        s_rdata_o <= {16'h0000, cfg_r};
      end else if (is_ofs(s_araddr_i, `RCF_CMD_OFS)) begin
        s_rdata_o <= 32'h00000000;
      end else if (is_ofs(s_araddr_i, `RCF_STAT_OFS)) begin
        s_rdata_o <= {20'h00000, press_r, armed_r, 3'b000, state_r};
      end else if (is_ofs(s_araddr_i, `RCF_IRQ_OFS)) begin
        s_rdata_o <= {28'h0000000, irq_sts_r};
      end else if (is_ofs(s_araddr_i, `RCF_MASK_OFS)) begin
        s_rdata_o <= {28'h0000000, irq_msk_r};
      end else if (is_ofs(s_araddr_i, `RCF_DTC_OFS)) begin
        s_rdata_o <= {23'h000000, dtc_vld_r, dtc_r};
      end else if (is_ofs(s_araddr_i, `RCF_FLT_OFS)) begin
        s_rdata_o <= {26'h0000000, shut_o, lamp_o};
      end else begin
        s_rresp_o <= `RCF_RESP_SLVERR;
      end
    end else if (s_rvalid_o && s_rready_i) begin
      s_rvalid_o  <= 1'b0;
      s_arready_o <= 1'b1;
    end
  end

  // Checks
  property p_probe_on_start;
    @(posedge ref_clk_i) disable iff (rst_i) start |=> net_probe_o && state_r == ST_PROBE;
  endproperty
  a_probe_on_start: assert property (p_probe_on_start) else $error("probe not raised");
  property p_retarder;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_r == ST_PROBE && net_done_i) |=> cfg_r.retarder == $past(net_i.retarder);
  endproperty
  a_retarder: assert property (p_retarder) else $error("retarder cfg wrong");
  property p_relay;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_r == ST_PROBE && net_done_i) |=> ##1 relay_en_o == $past(net_i.relay, 2);
  endproperty
  a_relay: assert property (p_relay) else $error("relay control wrong");
  property p_svfv;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_r == ST_PROBE && net_done_i && premium_i && xv_i.hold_r && xv_i.rel_l
       && xv_i.com_r) |=> cfg_r.six_sensor_five_valve;
  endproperty
  a_svfv: assert property (p_svfv) else $error("five valve not chosen");
  property p_counts;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_r == ST_PROBE && net_done_i && premium_i) |=> cfg_r.sensor_cnt == $past(sensor_cnt_i);
  endproperty
  a_counts: assert property (p_counts) else $error("sensor count wrong");
  property p_lamp;
    @(posedge ref_clk_i) disable iff (rst_i) fault_i |=> (lamp_o & $past(fault_lamp_i)) == $past(fault_lamp_i);
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp not lit");
  property p_dtc;
    @(posedge ref_clk_i) disable iff (rst_i) fault_i |=> dtc_vld_r && dtc_r == $past(fault_code_i);
  endproperty
  a_dtc: assert property (p_dtc) else $error("code not stored");
  property p_report;
    @(posedge ref_clk_i) disable iff (rst_i)
      (diag_dtc_req_i && dtc_vld_r && !fault_i) |=> diag_dtc_vld_o && diag_dtc_o == $past(dtc_r);
  endproperty
  a_report: assert property (p_report) else $error("code not sent");
  property p_nv;
    @(posedge ref_clk_i) disable iff (rst_i) (state_r == ST_PROBE && net_done_i) |=> nv_wr_o && nv_cfg_o == cfg_r;
  endproperty
  a_nv: assert property (p_nv) else $error("config not saved");
  property p_diag;
    @(posedge ref_clk_i) disable iff (rst_i) (diag_start_i && state_r == ST_IDLE) |=> state_r == ST_PROBE;
  endproperty
  a_diag: assert property (p_diag) else $error("tool start ignored");
  c_sw_start: cover property (@(posedge ref_clk_i) disable iff (rst_i) sw_start);
  c_done: cover property (@(posedge ref_clk_i) disable iff (rst_i) done_ev);
  c_fault: cover property (@(posedge ref_clk_i) disable iff (rst_i) sw_fault);
endmodule : rcf_top

// >>> rcf_params.svh
// Offsets, field positions, reset values and timing counts for the reconfiguration block
`ifndef RCF_PARAMS_SVH
`define RCF_PARAMS_SVH
`define RCF_CLK_HZ          25000000
`define RCF_PRESS_MIN_MS    100
`define RCF_PRESS_MAX_MS    5000
`define RCF_GAP_MAX_MS      2000
`define RCF_PAUSE_MS        3500
`define RCF_MS_CYC          (`RCF_CLK_HZ / 1000)
`define RCF_PRESS_CNT       7
`define RCF_CFG_OFS         12'h000
`define RCF_CMD_OFS         12'h004
`define RCF_STAT_OFS        12'h008
`define RCF_IRQ_OFS         12'h00c
`define RCF_MASK_OFS        12'h010
`define RCF_DTC_OFS         12'h014
`define RCF_NET_OFS         12'h018
`define RCF_WHL_OFS         12'h01c
`define RCF_FLT_OFS         12'h020
`define RCF_RESP_OKAY       2'b00
`define RCF_RESP_SLVERR     2'b10
`define RCF_IRQ_START       0
`define RCF_IRQ_DONE        1
`define RCF_IRQ_FAULT       2
`define RCF_IRQ_SWFLT       3
`define RCF_IRQ_W           4
`define RCF_CFG_RESET       16'h0000
`endif

// >>> rcf_pkg.sv
// Types shared by the reconfiguration block
package rcf_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_PROBE = 4'b0010,
    ST_SAVE  = 4'b0100,
    ST_DONE  = 4'b1000
  } rcf_state_t;
  typedef struct packed {
    logic       retarder;
    logic       relay_ctl;
    logic       traction_assist;
    logic       six_sensor_five_valve;
    logic [3:0] sensor_cnt;
    logic [3:0] pressure_modulator_valve_cnt;
    logic [3:0] rsvd;
  } rcf_cfg_t;
  typedef struct packed {
    logic       retarder;
    logic       relay;
    logic       relay_ok;
    logic       traction_assist;
  } rcf_net_t;
  typedef struct packed {
    logic hold_r;
    logic rel_l;
    logic com_r;
  } rcf_xv_t;
endpackage : rcf_pkg

// >>> rcf_far.sv
// Far-side model: vehicle network probe answer and non-volatile store
`timescale 1ns/1ps
module rcf_far (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Requests from the block
  input  wire logic probe_i,
  input  wire logic nv_wr_i,
  input  wire logic slow_i,
  // Answers
  output logic      done_o,
  output logic      ack_o
);
  int unsigned pcnt_r;
  int unsigned wcnt_r;

  // Slow answers stretch the probe so the unit must really wait
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pcnt_r <= 0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!probe_i || done_o) begin
        pcnt_r <= 0;
      end else if (pcnt_r == (slow_i ? 40 : 4)) begin
        done_o <= 1'b1;
        pcnt_r <= 0;
      end else begin
        pcnt_r <= pcnt_r + 1;
      end
    end
  end

  // Store acknowledges once per write request
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wcnt_r <= 0;
      ack_o  <= 1'b0;
    end else begin
      ack_o <= 1'b0;
      if (!nv_wr_i || ack_o) begin
        wcnt_r <= 0;
      end else if (wcnt_r == (slow_i ? 30 : 4)) begin
        ack_o  <= 1'b1;
        wcnt_r <= 0;
      end else begin
        wcnt_r <= wcnt_r + 1;
      end
    end
  end
endmodule : rcf_far

// >>> tb.sv
// Self-checking testbench for the reconfiguration block
`timescale 1ns/1ps
`include "rcf_params.svh"
module tb;
  import rcf_pkg::*;
  // Short millisecond keeps the switch timing inside the run budget
  localparam int MS = 4;
  logic        ref_clk_i, rst_i, switch_i, premium_i, diag_start_i, diag_dtc_req_i, slow;
  logic        diag_dtc_vld_o, net_probe_o, net_done_i, fault_i, relay_en_o, retarder_com_o;
  logic        nv_wr_o, nv_ack_i, s_awvalid_i, s_awready_o, s_wvalid_i, s_wready_o, irq_o;
  logic        s_bvalid_o, s_bready_i, s_arvalid_i, s_arready_o, s_rvalid_o, s_rready_i;
  logic [7:0]  diag_dtc_o, fault_code_i;
  logic [3:0]  sensor_cnt_i, valve_cnt_i, fault_lamp_i, lamp_o, s_wstrb_i;
  logic [1:0]  fault_shut_i, shut_o, s_bresp_o, s_rresp_o, rsp;
  logic [11:0] s_awaddr_i, s_araddr_i;
  logic [31:0] s_wdata_i, s_rdata_o, rd;
  rcf_net_t    net_i;
  rcf_xv_t     xv_i;
  rcf_cfg_t    nv_cfg_o;
  int          errors, n_tests;
  int          cyc = 0;

  always #20 ref_clk_i = ~ref_clk_i;

  rcf_top #(.MS_CYC(MS)) rcf_top_i (.ref_clk_i, .rst_i, .switch_i, .premium_i, .diag_start_i,
    .diag_dtc_req_i, .diag_dtc_vld_o, .diag_dtc_o, .net_probe_o, .net_done_i, .net_i,
    .sensor_cnt_i, .valve_cnt_i, .xv_i, .fault_i, .fault_code_i, .fault_lamp_i, .fault_shut_i,
    .lamp_o, .shut_o, .relay_en_o, .retarder_com_o, .nv_wr_o, .nv_cfg_o, .nv_ack_i,
    .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i, .s_wstrb_i, .s_wvalid_i, .s_wready_o,
    .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i, .s_arready_o,
    .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i, .irq_o);

  rcf_far rcf_far_i (.clk_i(ref_clk_i), .rst_i, .probe_i(net_probe_o), .nv_wr_i(nv_wr_o),
    .slow_i(slow), .done_o(net_done_i), .ack_o(nv_ack_i));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc_n(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : cyc_n

  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    s_awaddr_i  <= a;
    s_wdata_i   <= d;
    s_awvalid_i <= 1'b1;
    s_wvalid_i  <= 1'b1;
    s_bready_i  <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_awvalid_i && s_awready_o) s_awvalid_i <= 1'b0;
      if (s_wvalid_i && s_wready_o) s_wvalid_i <= 1'b0;
    end while (!s_bvalid_o && n < 50);
    s_bready_i <= 1'b0;
    rsp = s_bresp_o;
    if (n >= 50) errors++;
  endtask : axw

  task automatic axr(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    s_araddr_i  <= a;
    s_arvalid_i <= 1'b1;
    s_rready_i  <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_arvalid_i && s_arready_o) s_arvalid_i <= 1'b0;
    end while (!s_rvalid_o && n < 50);
    s_rready_i <= 1'b0;
    rd = s_rdata_o;
    rsp = s_rresp_o;
    if (n >= 50) errors++;
  endtask : axr

  // Bounded wait for the store handshake that ends a reconfiguration
  task automatic wait_store;
    int n;
    n = 0;
    while (!nv_ack_i && n < 400) begin
      @(posedge ref_clk_i);
      n++;
    end
    cyc_n(3);
    chk("store seen", 32'(n < 400), 32'h1);
  endtask : wait_store

  task automatic t_switch;
    // Held phase long enough to pass for a press; it must not count
    cyc_n(200 * MS);
    switch_i <= 1'b0;
    axr(`RCF_STAT_OFS);
    chk("armed", 32'(rd[7]), 32'h1);
    cyc_n(300 * MS);
    // Fourth press is too short and must not count
    for (int i = 0; i < 8; i++) begin
      switch_i <= 1'b1;
      cyc_n((i == 3 ? 50 : 300) * MS);
      switch_i <= 1'b0;
      cyc_n(300 * MS);
    end
    axr(`RCF_STAT_OFS);
    chk("press count", 32'(rd[11:8]), 32'h7);
    cyc_n(3050 * MS);
    axr(`RCF_IRQ_OFS);
    chk("early start", 32'(rd[1:0]), 32'h0);
    cyc_n(250 * MS);
    axr(`RCF_IRQ_OFS);
    chk("start done", 32'(rd[1:0]), 32'h3);
    axr(`RCF_CFG_OFS);
    chk("cfg switch", rd, 32'hf650);
    axw(`RCF_IRQ_OFS, 32'h3);
    $display("t_switch done");
  endtask : t_switch

  task automatic t_regs;
    axr(`RCF_NET_OFS);
    chk("unmapped rd resp", 32'(rsp), 32'(`RCF_RESP_SLVERR));
    chk("unmapped rd data", rd, 32'h0);
    axw(`RCF_WHL_OFS, 32'h1);
    chk("unmapped wr resp", 32'(rsp), 32'(`RCF_RESP_SLVERR));
    axw(`RCF_MASK_OFS, 32'h5);
    axr(`RCF_MASK_OFS);
    chk("mask", rd, 32'h5);
    axw(`RCF_CFG_OFS, 32'hffff);
    axr(`RCF_CFG_OFS);
    chk("cfg read only", rd, 32'hf650);
    axw(`RCF_MASK_OFS, 32'h0);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_tool;
    premium_i    <= 1'b0;
    net_i        <= 4'b0110;
    sensor_cnt_i <= 4'h2;
    slow         <= 1'b1;
    diag_start_i <= 1'b1;
    cyc_n(1);
    diag_start_i <= 1'b0;
    wait_store;
    chk("cfg tool", 32'(nv_cfg_o), 32'h7650);
    chk("relay en", 32'(relay_en_o), 32'h1);
    chk("retarder com", 32'(retarder_com_o), 32'h0);
    $display("t_tool done");
  endtask : t_tool

  task automatic t_cmd;
    premium_i    <= 1'b1;
    net_i        <= 4'b1001;
    sensor_cnt_i <= 4'h4;
    valve_cnt_i  <= 4'h4;
    xv_i         <= 3'b101;
    slow         <= 1'b0;
    axw(`RCF_CMD_OFS, 32'h1);
    wait_store;
    chk("cfg cmd", 32'(nv_cfg_o), 32'h8440);
    axr(`RCF_CFG_OFS);
    chk("cfg reg", rd, 32'h8440);
    chk("retarder com", 32'(retarder_com_o), 32'h1);
    chk("relay off", 32'(relay_en_o), 32'h0);
    $display("t_cmd done");
  endtask : t_cmd

  task automatic t_fault;
    int n;
    fault_code_i <= 8'h5a;
    fault_lamp_i <= 4'h3;
    fault_shut_i <= 2'h1;
    fault_i      <= 1'b1;
    cyc_n(1);
    fault_i <= 1'b0;
    cyc_n(2);
    chk("lamp", 32'(lamp_o), 32'h3);
    chk("shut", 32'(shut_o), 32'h1);
    chk("irq masked", 32'(irq_o), 32'h0);
    axr(`RCF_DTC_OFS);
    chk("dtc", rd, 32'h15a);
    fault_code_i <= 8'h21;
    fault_lamp_i <= 4'h8;
    fault_shut_i <= 2'h2;
    fault_i      <= 1'b1;
    cyc_n(1);
    fault_i <= 1'b0;
    cyc_n(2);
    axr(`RCF_FLT_OFS);
    chk("fault sticky", rd, 32'h3b);
    axw(`RCF_MASK_OFS, 32'h4);
    cyc_n(2);
    chk("irq up", 32'(irq_o), 32'h1);
    axw(`RCF_IRQ_OFS, 32'h4);
    cyc_n(2);
    chk("irq cleared", 32'(irq_o), 32'h0);
    diag_dtc_req_i <= 1'b1;
    n = 0;
    while (diag_dtc_vld_o !== 1'b1 && n < 5) begin
      @(posedge ref_clk_i);
      n++;
    end
    diag_dtc_req_i <= 1'b0;
    chk("dtc pulse", 32'(diag_dtc_vld_o), 32'h1);
    chk("dtc code", 32'(diag_dtc_o), 32'h21);
    $display("t_fault done");
  endtask : t_fault

  // Switch held past the press limit raises the switch fault, not before
  task automatic t_hold;
    switch_i <= 1'b1;
    cyc_n(4980 * MS);
    axr(`RCF_IRQ_OFS);
    chk("early switch fault", 32'(rd[`RCF_IRQ_SWFLT]), 32'h0);
    cyc_n(30 * MS);
    switch_i <= 1'b0;
    axr(`RCF_IRQ_OFS);
    chk("switch fault", 32'(rd[`RCF_IRQ_SWFLT]), 32'h1);
    $display("t_hold done");
  endtask : t_hold

  task automatic summarize;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  // Whole run is about 55k cycles; ceiling leaves a wide margin
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    ref_clk_i = 1'b0;
    rst_i = 1'b1;
    switch_i = 1'b1;
    premium_i = 1'b1;
    slow = 1'b0;
    diag_start_i = 1'b0;
    diag_dtc_req_i = 1'b0;
    fault_i = 1'b0;
    fault_code_i = 8'h00;
    fault_lamp_i = 4'h0;
    fault_shut_i = 2'h0;
    net_i = 4'hf;
    sensor_cnt_i = 4'h6;
    valve_cnt_i = 4'h5;
    xv_i = 3'b111;
    s_awaddr_i = 12'h000;
    s_awvalid_i = 1'b0;
    s_wdata_i = 32'h0;
    s_wstrb_i = 4'hf;
    s_wvalid_i = 1'b0;
    s_bready_i = 1'b0;
    s_araddr_i = 12'h000;
    s_arvalid_i = 1'b0;
    s_rready_i = 1'b0;
    errors = 0;
    n_tests = 0;
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_switch();
    t_regs();
    t_tool();
    t_cmd();
    t_fault();
    t_hold();
    summarize();
  end
endmodule : tb
